// ---- logic/etp_cmd_serializer.sv ----
// Serializer that sends command codes on the slow emulator interface clock
`default_nettype none
module etp_cmd_serializer
   import etp_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ifTick,
   input wire logic sendReq,
   input wire logic [etp_pkg::CMD_W-1:0] sendCode,
   output logic busy,
   output logic ifData,
   output logic ifFrame
);
   logic [CMD_W-1:0] shift_reg, shift_next;
   logic [CMD_BITS_W-1:0] bits_reg, bits_next;
   logic pend_reg, pend_next;
   logic data_reg, data_next;
   logic frame_reg, frame_next;

   always_comb begin
      shift_next = shift_reg;
      bits_next = bits_reg;
      pend_next = pend_reg | sendReq;
      data_next = data_reg;
      frame_next = frame_reg;
      if (ifTick) begin
         if (bits_reg != '0) begin
            data_next = shift_reg[CMD_W-1];
            shift_next = {shift_reg[CMD_W-2:0], 1'b0};
            bits_next = bits_reg - 1'b1;
            frame_next = 1'b1;
         end else if (pend_reg) begin
            // Code latched only on a tick so bits stay aligned to the slow clock
            shift_next = {sendCode[CMD_W-2:0], 1'b0};
            data_next = sendCode[CMD_W-1];
            bits_next = CMD_BITS_W'(CMD_W - 1);
            frame_next = 1'b1;
            pend_next = sendReq;
         end else begin
            frame_next = 1'b0;
            data_next = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         shift_reg <= CMD_IDLE;
         bits_reg <= '0;
         pend_reg <= 1'b0;
         data_reg <= 1'b0;
         frame_reg <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         bits_reg <= bits_next;
         pend_reg <= pend_next;
         data_reg <= data_next;
         frame_reg <= frame_next;
      end
   end

   assign busy = pend_reg | (bits_reg != '0);
   assign ifData = data_reg;
   assign ifFrame = frame_reg;
endmodule
`default_nettype wire

// ---- logic/etp_pkg.sv ----
// Shared constants and types for the emulator trigger and power-on debug block
`default_nettype none
package etp_pkg;
   // Core clock rate and stabilization time
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned STAB_TIME_US = 2000;
   localparam int unsigned STAB_CYCLES = (STAB_TIME_US * (CLK_HZ / 1_000_000));
   localparam int unsigned STAB_CNT_W = 15;
   // Emulator interface clock divider (core cycles per interface tick)
   localparam int unsigned IF_DIV = 8;
   localparam int unsigned IF_DIV_W = 4;
   // Command frame
   localparam int unsigned CMD_W = 8;
   localparam logic [7:0] CMD_BREAK = 8'h0081;
   localparam logic [7:0] CMD_IDLE = 8'h0000;
   localparam int unsigned CMD_BITS_W = 4;
   // Edge selection
   localparam logic EDGE_RISING = 1'b0;
   localparam logic EDGE_FALLING = 1'b1;

   typedef enum logic [2:0] {
      PWR_OFF = 3'b001,
      PWR_QUAL = 3'b010,
      PWR_ON = 3'b100
   } etp_pwr_state_type;
endpackage
`default_nettype wire

// ---- logic/etp_top.sv ----
// Emulator external trigger, program running output and power-on debug sequencer
`default_nettype none
module etp_top
   import etp_pkg::*;
#(
   parameter int unsigned STAB_COUNT = etp_pkg::STAB_CYCLES
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic external_trigger_in,
   input wire logic edgeSelect,
   input wire logic triggerEnable,
   input wire logic user_supply_voltage,
   input wire logic powerOnDebugEnable,
   input wire logic userProgramRunning,
   output logic program_running_out,
   output logic power_level_hold,
   output logic userResetRelease,
   output logic emulatorFuncEnable,
   output logic breakRequest,
   output logic ifClkEn,
   output logic ifCmdData,
   output logic ifCmdFrame
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic trigMeta_reg, trigSync_reg, trigPrev_reg;
   logic supMeta_reg, supSync_reg;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         trigMeta_reg <= 1'b0;
         trigSync_reg <= 1'b0;
         trigPrev_reg <= 1'b0;
         supMeta_reg <= 1'b0;
         supSync_reg <= 1'b0;
      end else begin
         trigMeta_reg <= external_trigger_in;
         trigSync_reg <= trigMeta_reg;
         trigPrev_reg <= trigSync_reg;
         supMeta_reg <= user_supply_voltage;
         supSync_reg <= supMeta_reg;
      end
   end

   // ------------------------------------------------------------
   // Edge detection and break request
   // ------------------------------------------------------------
   logic edgeHit;
   logic hold_next;
   logic break_reg, break_next;

   always_comb begin
      // Rising when select low, falling when high
      if (edgeSelect == EDGE_FALLING) begin
         edgeHit = trigPrev_reg & ~trigSync_reg;
      end else begin
         edgeHit = ~trigPrev_reg & trigSync_reg;
      end
      // Gated by next hold so no break pulse outlives a hold drop
      break_next = edgeHit & triggerEnable & hold_next;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         break_reg <= 1'b0;
      end else begin
         break_reg <= break_next;
      end
   end

   // ------------------------------------------------------------
   // Interface clock divider and command serializer
   // ------------------------------------------------------------
   logic [IF_DIV_W-1:0] div_reg, div_next;
   logic tick_reg, tick_next;
   logic serBusy, serData, serFrame;
   logic data_reg, frame_reg;

   always_comb begin
      tick_next = (div_reg == IF_DIV_W'(IF_DIV - 1));
      div_next = tick_next ? '0 : div_reg + 1'b1;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
         data_reg <= 1'b0;
         frame_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         tick_reg <= tick_next;
         data_reg <= serData;
         frame_reg <= serFrame;
      end
   end

   // Break slip comes from this slow serial path, by design
   etp_cmd_serializer u_ser (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ifTick(tick_reg),
      .sendReq(break_reg),
      .sendCode(CMD_BREAK),
      .busy(serBusy),
      .ifData(serData),
      .ifFrame(serFrame)
   );

   // ------------------------------------------------------------
   // Power-on debug sequencer
   // ------------------------------------------------------------
   etp_pwr_state_type state_reg, state_next;
   logic [STAB_CNT_W-1:0] cnt_reg, cnt_next;
   logic hold_reg;
   logic rel_reg, rel_next;
   logic run_reg, run_next;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         PWR_OFF: begin
            cnt_next = '0;
            if (supSync_reg) begin
               state_next = PWR_QUAL;
            end
         end
         PWR_QUAL: begin
            if (!supSync_reg) begin
               state_next = PWR_OFF;
               cnt_next = '0;
            end else if (cnt_reg == STAB_CNT_W'(STAB_COUNT - 1)) begin
               state_next = PWR_ON;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         PWR_ON: begin
            if (!supSync_reg) begin
               state_next = PWR_OFF;
            end
         end
         default: begin
            state_next = PWR_OFF;
         end
      endcase
      // Disabled function: hold stays high whatever the supply; a part without support never sees it
      hold_next = powerOnDebugEnable ? (state_next == PWR_ON) : 1'b1;
      rel_next = hold_next;
      run_next = userProgramRunning & hold_next;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg <= PWR_OFF;
         cnt_reg <= '0;
         hold_reg <= 1'b0;
         rel_reg <= 1'b0;
         run_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         hold_reg <= hold_next;
         rel_reg <= rel_next;
         run_reg <= run_next;
      end
   end

   assign program_running_out = run_reg;
   assign power_level_hold = hold_reg;
   assign userResetRelease = rel_reg;
   assign emulatorFuncEnable = hold_reg;
   assign breakRequest = break_reg;
   assign ifClkEn = tick_reg;
   assign ifCmdData = data_reg;
   assign ifCmdFrame = frame_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_supplyUp;
      supSync_reg && state_reg == PWR_OFF;
   endsequence

   a_rise_break: assert property (@(posedge core_clk) disable iff (sys_rst)
      (edgeSelect == EDGE_RISING && triggerEnable && hold_next
       && $rose(trigSync_reg) && $stable(edgeSelect) && $stable(triggerEnable))
       |=> breakRequest)
      else $error("rising edge did not raise break");
   a_fall_break: assert property (@(posedge core_clk) disable iff (sys_rst)
      (edgeSelect == EDGE_FALLING && $rose(trigSync_reg)) |=> !breakRequest)
      else $error("break on wrong edge");
   a_break_frame: assert property (@(posedge core_clk) disable iff (sys_rst)
      (breakRequest && !serBusy) |-> ##[1:20] ifCmdFrame)
      else $error("break command not sent");
   a_low_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      (powerOnDebugEnable && !supSync_reg) |=> !power_level_hold)
      else $error("hold not low with supply off");
   a_stab_wait: assert property (@(posedge core_clk) disable iff (sys_rst)
      (powerOnDebugEnable and s_supplyUp) |=> ##1 !power_level_hold)
      else $error("hold released without stabilization");
   a_hold_release: assert property (@(posedge core_clk) disable iff (sys_rst)
      power_level_hold == userResetRelease)
      else $error("reset release not tied to hold");
   a_func_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      !power_level_hold |-> (!breakRequest && !program_running_out))
      else $error("functions active while disconnected");
   a_run_out: assert property (@(posedge core_clk) disable iff (sys_rst)
      (userProgramRunning && hold_next) |=> program_running_out)
      else $error("running output not high");
   a_restart_cnt: assert property (@(posedge core_clk) disable iff (sys_rst)
      (state_reg == PWR_QUAL && !supSync_reg) |=> (cnt_reg == '0))
      else $error("count not restarted");
endmodule
`default_nettype wire

// ---- tb/emulator_trigger_and_power_on_debug_test.sv ----
// Self-checking bench for the trigger and power-on debug block
`default_nettype none
module emulator_trigger_and_power_on_debug_test;
   timeunit 1ns;
   timeprecision 1ns;
   import etp_pkg::*;
   localparam int unsigned STAB = 20;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic trigPin = 1'b0;
   logic edgeSel = 1'b0;
   logic trigEn = 1'b1;
   logic supply = 1'b0; // Comparator flag; threshold is the controller's choice
   logic podEn = 1'b1;
   logic progRun = 1'b0;
   logic rxClear = 1'b1;
   logic progOut, hold, rstRel, funcEn, brk, ifClkEn, ifData, ifFrame, rxDone;
   logic [CMD_W-1:0] rxCode;
   int n_mismatch = 0;
   int n_tests = 0;
   int brkCnt = 0;
   int cycles = 0;

   etp_top #(.STAB_COUNT(STAB)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
      .external_trigger_in(trigPin), .edgeSelect(edgeSel), .triggerEnable(trigEn),
      .user_supply_voltage(supply), .powerOnDebugEnable(podEn),
      .userProgramRunning(progRun), .program_running_out(progOut),
      .power_level_hold(hold), .userResetRelease(rstRel), .emulatorFuncEnable(funcEn),
      .breakRequest(brk), .ifClkEn(ifClkEn), .ifCmdData(ifData), .ifCmdFrame(ifFrame));
   etp_far_model far_u (.core_clk(core_clk), .rxClear(rxClear), .ifClkEn(ifClkEn),
      .ifCmdData(ifData), .ifCmdFrame(ifFrame), .rxCode(rxCode), .rxDone(rxDone));

   // -----------------------------
   // Clock, watchdog, helpers
   // -----------------------------
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (brk === 1'b1) brkCnt++;
      if (cycles == 5000) begin
         n_mismatch++;
         $display("MISMATCH %0t timeout", $time);
         results();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic check(input logic got, input logic exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task automatic results();
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Toggle the pin once; a break must follow only on the chosen edge
   task automatic edge1(input logic expBrk);
      int b;
      b = brkCnt;
      rxClear = 1'b1;
      trigPin = ~trigPin;
      tick(1);
      rxClear = 1'b0;
      tick(6);
      check(brkCnt != b, expBrk, "break request");
      if (expBrk) begin
         for (int i = 0; i < 120 && rxDone !== 1'b1; i++) tick(1);
         check(rxCode === CMD_BREAK, 1'b1, "command code");
      end
   endtask

   // -----------------------------
   // Scenarios
   // -----------------------------
   task automatic t_power();
      check(hold, 1'b0, "hold while supply low");
      check(funcEn, 1'b0, "functions while hold low");
      supply = 1'b1;
      tick(10);
      supply = 1'b0;
      tick(6);
      check(hold, 1'b0, "hold after short pulse");
      supply = 1'b1;
      tick(STAB + 2);
      check(hold, 1'b0, "hold before interval");
      tick(1);
      check(hold, 1'b1, "hold after interval");
      check(rstRel, 1'b1, "reset release");
      check(funcEn, 1'b1, "functions enabled");
      $display("test power done");
   endtask
   task automatic t_external_trigger_in();
      edgeSel = EDGE_RISING;
      tick(2);
      edge1(1'b1);
      edge1(1'b0);
      edgeSel = EDGE_FALLING;
      tick(2);
      edge1(1'b0);
      edge1(1'b1);
      trigEn = 1'b0;
      edge1(1'b0);
      edge1(1'b0);
      trigEn = 1'b1;
      $display("test trigger done");
   endtask
   task automatic t_run();
      progRun = 1'b1;
      tick(3);
      check(progOut, 1'b1, "running output");
      supply = 1'b0;
      tick(6);
      check(hold, 1'b0, "hold after supply drop");
      check(progOut, 1'b0, "running output gated");
      check(funcEn, 1'b0, "functions disabled");
      podEn = 1'b0;
      tick(3);
      check(hold, 1'b1, "hold with debug off");
      check(progOut, 1'b1, "running with debug off");
      progRun = 1'b0;
      tick(2);
      check(progOut, 1'b0, "running output after stop");
      $display("test run done");
   endtask

   initial begin
      tick(4);
      sys_rst = 1'b0;
      tick(2);
      t_power();
      t_external_trigger_in();
      t_run();
      results();
   end
endmodule
`default_nettype wire

// ---- tb/etp_far_model.sv ----
// Far-side model that collects command frames from the block
`default_nettype none
module etp_far_model
   import etp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rxClear,
   input wire logic ifClkEn,
   input wire logic ifCmdData,
   input wire logic ifCmdFrame,
   output logic [etp_pkg::CMD_W-1:0] rxCode,
   output logic rxDone
);
   timeunit 1ns;
   timeprecision 1ns;
   int nBits = 0;
   // -----------------------------
   // Frame capture, MSB first
   // -----------------------------
   always @(posedge core_clk) begin
      if (rxClear) begin
         nBits <= 0;
         rxCode <= '0;
         rxDone <= 1'b0;
      end else if (ifClkEn && ifCmdFrame && nBits < CMD_W) begin
         rxCode <= {rxCode[CMD_W-2:0], ifCmdData};
         nBits <= nBits + 1;
         if (nBits == CMD_W - 1) begin
            rxDone <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire
